// [core/mft_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_mem #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 50,
   parameter int unsigned AW = 6
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset on the array: unused entries are masked by the reader
   always_ff @(posedge sys_clk)
   begin
      if (ce && we && (32'(waddr) < DEPTH))
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_q <= '0;
      end
      else if (ce)
      begin
         rdata_q <= (32'(raddr) < DEPTH) ? mem[raddr] : '0;
      end
   end
endmodule // mft_mem
`default_nettype wire

// [core/mft_table.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - store first hop toward each node
// - equal first hop and node means direct
// - slot share 128 means every slot
// - slot share 4 means 4 of 128
// - node count readable at 7001
// - node ids at 7002 through 7051
// - first-hop count readable at 7301
// - first hops at 7302 through 7351
// - slot-share count readable at 7601
// - slot shares at 7602 through 7651
// - slave id base at 6502, reset 11
// - slave map from base at 6504 onward
// - node id is serial low 16 bits
// - indices filled in join order
module mft_table #(
   parameter int unsigned SERIAL_W = 32,
   parameter int unsigned ENTRIES = mft_pkg::ENTRIES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [15:0] addr,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data_q,
   output logic rd_valid_q,
   input wire logic join_valid,
   input wire logic [SERIAL_W-1:0] join_node_serial,
   input wire logic [SERIAL_W-1:0] join_hop_serial,
   input wire logic [15:0] join_slot_share,
   output logic join_ready,
   input wire logic map_wr,
   input wire logic [15:0] map_slave_id,
   input wire logic [SERIAL_W-1:0] map_node_serial,
   output logic [15:0] slave_id_base_q,
   output logic last_direct_q,
   output logic last_every_slot_q,
   output logic [5:0] entry_count_q
);
   localparam int unsigned AW = mft_pkg::IDX_W;

   logic join_take;
   logic [15:0] node_id;
   logic [15:0] hop_id;
   logic [15:0] share_val;
   logic node_hit, hop_hit, share_hit, map_hit;
   logic [AW-1:0] node_idx, hop_idx, share_idx, map_idx, tab_idx;
   logic [15:0] map_diff;
   logic map_in_range;
   logic [15:0] node_rd, hop_rd, share_rd, map_rd;
   logic [ENTRIES-1:0] map_vld_q;
   mft_pkg::mft_sel_t sel_d, sel_q;
   logic [AW-1:0] idx_q;
   logic stage1_q;
   logic [15:0] rd_data_d;

   // one common count: all three sections grow together
   assign join_ready = (32'(entry_count_q) < ENTRIES);
   assign join_take = join_valid && join_ready;
   assign node_id = join_node_serial[15:0];
   assign hop_id = join_hop_serial[15:0];
   // shares above the slot total are clamped: no child gets more than all slots
   assign share_val = (join_slot_share > mft_pkg::SLOT_SHARE_ALL) ?
      mft_pkg::SLOT_SHARE_ALL : join_slot_share;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         entry_count_q <= '0;
      end
      else if (ce && join_take)
      begin
         entry_count_q <= entry_count_q + 6'h01;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         last_direct_q <= 1'b0;
         last_every_slot_q <= 1'b0;
      end
      else if (ce && join_take)
      begin
         last_direct_q <= (node_id == hop_id);
         last_every_slot_q <= (share_val == mft_pkg::SLOT_SHARE_ALL);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         slave_id_base_q <= mft_pkg::SLAVE_ID_BASE_RST;
      end
      else if (ce && wr_en && (addr == mft_pkg::SLAVE_ID_BASE))
      begin
         slave_id_base_q <= wr_data;
      end
   end

   // map slot = slave id minus base, taken at the time of the update
   assign map_diff = map_slave_id - slave_id_base_q;
   assign map_in_range = (map_slave_id >= slave_id_base_q) && (map_diff < 16'(ENTRIES));

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         map_vld_q <= '0;
      end
      else if (ce && map_wr && map_in_range)
      begin
         map_vld_q[map_diff[AW-1:0]] <= 1'b1;
      end
   end

   mft_win #(.BASE(mft_pkg::NODE_ID_TABLE_FIRST), .N(ENTRIES), .AW(AW)) u_win_node (
      .addr(addr),
      .hit(node_hit),
      .idx(node_idx)
   );
   mft_win #(.BASE(mft_pkg::FIRST_HOP_TABLE_FIRST), .N(ENTRIES), .AW(AW)) u_win_hop (
      .addr(addr),
      .hit(hop_hit),
      .idx(hop_idx)
   );
   mft_win #(.BASE(mft_pkg::SLOT_SHARE_TABLE_FIRST), .N(ENTRIES), .AW(AW)) u_win_share (
      .addr(addr),
      .hit(share_hit),
      .idx(share_idx)
   );
   mft_win #(.BASE(mft_pkg::SLAVE_TO_NODE_MAP_FIRST), .N(ENTRIES), .AW(AW)) u_win_map (
      .addr(addr),
      .hit(map_hit),
      .idx(map_idx)
   );

   assign tab_idx = node_hit ? node_idx : (hop_hit ? hop_idx : share_idx);

   mft_mem #(.WIDTH(16), .DEPTH(ENTRIES), .AW(AW)) u_mem_node (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .we(join_take),
      .waddr(entry_count_q),
      .wdata(node_id),
      .raddr(tab_idx),
      .rdata_q(node_rd)
   );
   mft_mem #(.WIDTH(16), .DEPTH(ENTRIES), .AW(AW)) u_mem_hop (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .we(join_take),
      .waddr(entry_count_q),
      .wdata(hop_id),
      .raddr(tab_idx),
      .rdata_q(hop_rd)
   );
   mft_mem #(.WIDTH(16), .DEPTH(ENTRIES), .AW(AW)) u_mem_share (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .we(join_take),
      .waddr(entry_count_q),
      .wdata(share_val),
      .raddr(tab_idx),
      .rdata_q(share_rd)
   );
   mft_mem #(.WIDTH(16), .DEPTH(ENTRIES), .AW(AW)) u_mem_map (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .we(map_wr && map_in_range),
      .waddr(map_diff[AW-1:0]),
      .wdata(map_node_serial[15:0]),
      .raddr(map_idx),
      .rdata_q(map_rd)
   );

   always_comb
   begin
      if (addr == mft_pkg::SLAVE_ID_BASE)
      begin
         sel_d = mft_pkg::MFT_SEL_BASE;
      end
      else if (map_hit)
      begin
         sel_d = mft_pkg::MFT_SEL_MAP;
      end
      else if ((addr == mft_pkg::NODE_ID_ENTRY_COUNT) || (addr == mft_pkg::FIRST_HOP_ENTRY_COUNT)
         || (addr == mft_pkg::SLOT_SHARE_ENTRY_COUNT))
      begin
         sel_d = mft_pkg::MFT_SEL_CNT;
      end
      else if (node_hit)
      begin
         sel_d = mft_pkg::MFT_SEL_NODE;
      end
      else if (hop_hit)
      begin
         sel_d = mft_pkg::MFT_SEL_HOP;
      end
      else if (share_hit)
      begin
         sel_d = mft_pkg::MFT_SEL_SHARE;
      end
      else
      begin
         sel_d = mft_pkg::MFT_SEL_NONE;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         sel_q <= mft_pkg::MFT_SEL_NONE;
         idx_q <= '0;
         stage1_q <= 1'b0;
      end
      else if (ce)
      begin
         sel_q <= sel_d;
         idx_q <= map_hit ? map_idx : tab_idx;
         stage1_q <= rd_en;
      end
   end

   // count is checked at stage two, so a join in the read cycle is counted though its data was read stale at stage one
   always_comb
   begin
      rd_data_d = '0;
      case (sel_q)
         mft_pkg::MFT_SEL_BASE: rd_data_d = slave_id_base_q;
         mft_pkg::MFT_SEL_MAP: rd_data_d = map_vld_q[idx_q] ? map_rd : '0;
         mft_pkg::MFT_SEL_CNT: rd_data_d = {10'h000, entry_count_q};
         mft_pkg::MFT_SEL_NODE: rd_data_d = (idx_q < entry_count_q) ? node_rd : '0;
         mft_pkg::MFT_SEL_HOP: rd_data_d = (idx_q < entry_count_q) ? hop_rd : '0;
         mft_pkg::MFT_SEL_SHARE: rd_data_d = (idx_q < entry_count_q) ? share_rd : '0;
         default: rd_data_d = '0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rd_data_q <= '0;
         rd_valid_q <= 1'b0;
      end
      else if (ce)
      begin
         rd_data_q <= stage1_q ? rd_data_d : '0;
         rd_valid_q <= stage1_q;
      end
   end

   // checks other than a_count_bound and a_base_reset assume ce held high; a low ce disables them
   a_count_bound: assert property (@(posedge sys_clk) disable iff (reset)
      32'(entry_count_q) <= ENTRIES) else $error("entry count above table size");
   a_join_append: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      join_valid && join_ready |=> entry_count_q == $past(entry_count_q) + 6'h01)
      else $error("join did not append one entry");
   a_full_ignore: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      !join_ready |=> $stable(entry_count_q)) else $error("full table still grew");
   a_read_timing: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      rd_en |-> ##2 rd_valid_q) else $error("read answer not two cycles later");
   a_base_write: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      wr_en && addr == mft_pkg::SLAVE_ID_BASE |=> slave_id_base_q == $past(wr_data))
      else $error("base register write lost");
   a_base_reset: assert property (@(posedge sys_clk)
      $past(reset) |-> slave_id_base_q == 16'h000b) else $error("base not 11 after reset");
   a_unused_zero: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      (rd_en && (node_hit || hop_hit || share_hit) && tab_idx >= entry_count_q && !join_valid)
      ##1 !join_valid |=> rd_data_q == 16'h0000) else $error("unused entry not zero");
   a_count_read: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      (rd_en && addr == mft_pkg::FIRST_HOP_ENTRY_COUNT && !join_valid) ##1 !join_valid
      |=> rd_data_q == {10'h000, entry_count_q}) else $error("count read wrong");
   a_direct_flag: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      join_valid && join_ready |=> last_direct_q ==
      ($past(join_node_serial[15:0]) == $past(join_hop_serial[15:0])))
      else $error("direct link flag wrong");
   a_every_slot: assert property (@(posedge sys_clk) disable iff (reset || !ce)
      join_valid && join_ready && join_slot_share >= 16'h0080 |=> last_every_slot_q)
      else $error("full share not flagged");
   c_join: cover property (@(posedge sys_clk) disable iff (reset) join_valid && join_ready);
   c_full: cover property (@(posedge sys_clk) disable iff (reset) join_valid && !join_ready);
   c_map_read: cover property (@(posedge sys_clk) disable iff (reset)
      rd_en && map_hit ##2 rd_data_q != 16'h0000);
   c_table_read: cover property (@(posedge sys_clk) disable iff (reset)
      rd_en && hop_hit ##2 rd_data_q != 16'h0000);
endmodule // mft_table
`default_nettype wire

// [core/mft_win.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_win #(
   parameter logic [15:0] BASE = 16'h0000,
   parameter int unsigned N = 50,
   parameter int unsigned AW = 6
) (
   input wire logic [15:0] addr,
   output logic hit,
   output logic [AW-1:0] idx
);
   logic [15:0] diff;

   assign diff = addr - BASE;
   assign hit = (addr >= BASE) && (diff < 16'(N));
   assign idx = diff[AW-1:0];
endmodule // mft_win
`default_nettype wire

// [inc/mft_pkg.sv]
package mft_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ENTRIES = 50;
   localparam int unsigned IDX_W = 6;
   localparam logic [15:0] SLAVE_ID_BASE = 16'h1966;
   localparam logic [15:0] SLAVE_TO_NODE_MAP_FIRST = 16'h1968;
   localparam logic [15:0] NODE_ID_ENTRY_COUNT = 16'h1b59;
   localparam logic [15:0] NODE_ID_TABLE_FIRST = 16'h1b5a;
   localparam logic [15:0] FIRST_HOP_ENTRY_COUNT = 16'h1c85;
   localparam logic [15:0] FIRST_HOP_TABLE_FIRST = 16'h1c86;
   localparam logic [15:0] SLOT_SHARE_ENTRY_COUNT = 16'h1db1;
   localparam logic [15:0] SLOT_SHARE_TABLE_FIRST = 16'h1db2;
   localparam logic [15:0] SLAVE_ID_BASE_RST = 16'h000b;
   localparam logic [15:0] SLOT_SHARE_ALL = 16'h0080;
   localparam logic [15:0] SLOT_SHARE_LOW = 16'h0004;
   localparam int unsigned READ_LATENCY = 2;
   typedef enum logic [6:0] {
      MFT_SEL_NONE = 7'h01,
      MFT_SEL_BASE = 7'h02,
      MFT_SEL_MAP = 7'h04,
      MFT_SEL_CNT = 7'h08,
      MFT_SEL_NODE = 7'h10,
      MFT_SEL_HOP = 7'h20,
      MFT_SEL_SHARE = 7'h40
   } mft_sel_t;
endpackage

// [sim/mft_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_host (
   input wire logic sys_clk,
   input wire logic [15:0] rd_data_q,
   input wire logic rd_valid_q,
   output logic rd_en,
   output logic wr_en,
   output logic [15:0] addr,
   output logic [15:0] wr_data
);
   initial
   begin
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = 16'h0000;
      wr_data = 16'h0000;
   end
   // one register per request; answer awaited with a bound
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge sys_clk);
      rd_en = 1'b0;
      // released address is inverted so a stale sample cannot pass
      addr = ~a;
      d = 16'hxxxx;
      repeat (4)
      begin
         if (rd_valid_q === 1'b1)
         begin
            d = rd_data_q;
         end
         @(negedge sys_clk);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(negedge sys_clk);
      wr_en = 1'b1;
      addr = a;
      wr_data = v;
      @(negedge sys_clk);
      wr_en = 1'b0;
      addr = ~a;
      wr_data = ~v;
   endtask
endmodule // mft_host
`default_nettype wire

// [sim/mft_table_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mft_table_tb;
   logic sys_clk, reset, rd_en, wr_en, rd_valid_q, join_valid, join_ready, map_wr;
   logic last_direct_q, last_every_slot_q, ce;
   logic [15:0] addr, wr_data, rd_data_q, join_slot_share, map_slave_id, slave_id_base_q;
   logic [31:0] join_node_serial, join_hop_serial, map_node_serial;
   logic [5:0] entry_count_q;
   int error_cnt, num_checks, cycles;
   mft_table dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .rd_en(rd_en),
      .wr_en(wr_en), .addr(addr), .wr_data(wr_data), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .join_valid(join_valid), .join_node_serial(join_node_serial),
      .join_hop_serial(join_hop_serial), .join_slot_share(join_slot_share),
      .join_ready(join_ready), .map_wr(map_wr), .map_slave_id(map_slave_id),
      .map_node_serial(map_node_serial), .slave_id_base_q(slave_id_base_q),
      .last_direct_q(last_direct_q), .last_every_slot_q(last_every_slot_q),
      .entry_count_q(entry_count_q));
   mft_host host (.sys_clk(sys_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
      .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      host.rd(a, d);
      check(d, exp);
   endtask
   task automatic join_node(input logic [31:0] n, input logic [31:0] h, input logic [15:0] s);
      @(negedge sys_clk);
      join_valid = 1'b1;
      join_node_serial = n;
      join_hop_serial = h;
      join_slot_share = s;
      @(negedge sys_clk);
      join_valid = 1'b0;
   endtask
   task automatic map_node(input logic [15:0] id, input logic [31:0] n);
      @(negedge sys_clk);
      map_wr = 1'b1;
      map_slave_id = id;
      map_node_serial = n;
      @(negedge sys_clk);
      map_wr = 1'b0;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         conclude();
      end
   end
   initial
   begin
      error_cnt = 0;
      num_checks = 0;
      cycles = 0;
      reset = 1'b1;
      ce = 1'b1;
      join_valid = 1'b0;
      join_node_serial = 32'h0;
      join_hop_serial = 32'h0;
      join_slot_share = 16'h0000;
      map_wr = 1'b0;
      map_slave_id = 16'h0000;
      map_node_serial = 32'h0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      rchk(16'h1966, 16'h000b);
      rchk(16'h1b59, 16'h0000);
      rchk(16'h1b5a, 16'h0000);
      rchk(16'h1000, 16'h0000);
      host.wr(16'h1966, 16'h0014);
      rchk(16'h1966, 16'h0014);
      // read-only count must ignore the write
      host.wr(16'h1b59, 16'h1234);
      rchk(16'h1b59, 16'h0000);
      join_node(32'h0001a8cb, 32'h0001a8cb, 16'h0080);
      check({15'h0, last_direct_q}, 16'h0001);
      check({15'h0, last_every_slot_q}, 16'h0001);
      join_node(32'h0002add4, 32'h0003b42b, 16'h0004);
      check({15'h0, last_direct_q}, 16'h0000);
      check({15'h0, last_every_slot_q}, 16'h0000);
      rchk(16'h1b59, 16'h0002);
      rchk(16'h1c85, 16'h0002);
      rchk(16'h1db1, 16'h0002);
      rchk(16'h1b5a, 16'ha8cb);
      rchk(16'h1b5b, 16'hadd4);
      rchk(16'h1c86, 16'ha8cb);
      rchk(16'h1c87, 16'hb42b);
      rchk(16'h1db2, 16'h0080);
      rchk(16'h1db3, 16'h0004);
      rchk(16'h1b5c, 16'h0000);
      rchk(16'h1c88, 16'h0000);
      rchk(16'h1db4, 16'h0000);
      // base is now 20, so slave 20 lands in the first map slot
      map_node(16'h0014, 32'h0005abcd);
      map_node(16'h0015, 32'h00061234);
      map_node(16'h0013, 32'h00077777);
      map_node(16'h0046, 32'h00088888);
      rchk(16'h1968, 16'habcd);
      rchk(16'h1969, 16'h1234);
      rchk(16'h196a, 16'h0000);
      rchk(16'h1999, 16'h0000);
      // low enable must freeze both a join and a base write
      @(negedge sys_clk);
      ce = 1'b0;
      join_node(32'h0000cccc, 32'h0000cccc, 16'h0080);
      host.wr(16'h1966, 16'h0030);
      check({10'h000, entry_count_q}, 16'h0002);
      check(slave_id_base_q, 16'h0014);
      ce = 1'b1;
      for (int i = 3; i <= 50; i++)
         join_node(32'h00090000 | i, 32'h0000ffff, 16'h0020);
      check({10'h000, entry_count_q}, 16'h0032);
      check({15'h0, join_ready}, 16'h0000);
      join_node(32'h0000eeee, 32'h0000eeee, 16'h0080);
      check({10'h000, entry_count_q}, 16'h0032);
      rchk(16'h1b8b, 16'h0032);
      rchk(16'h1b5c, 16'h0003);
      rchk(16'h1c88, 16'hffff);
      rchk(16'h1c90, 16'hffff);
      rchk(16'h1de3, 16'h0020);
      rchk(16'h1db1, 16'h0032);
      rchk(16'h1b8c, 16'h0000);
      // mid-run reset clears table and map and returns base to 11
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      rchk(16'h1966, 16'h000b);
      rchk(16'h1b59, 16'h0000);
      rchk(16'h1b5a, 16'h0000);
      rchk(16'h1968, 16'h0000);
      conclude();
   end
endmodule // mft_table_tb
`default_nettype wire
